// ===== core/ifd_cfg.svh
// Offsets, field positions, codes and timing counts of the instruction decoder
`ifndef IFD_CFG_SVH
`define IFD_CFG_SVH

// ----------------------------------------------------------------
// Word and field layout
// ----------------------------------------------------------------
`define IFD_WORD_W      16
`define IFD_GRP_HI      15
`define IFD_GRP_LO      14
`define IFD_BYTE_OP_HI  13
`define IFD_BYTE_OP_LO  9
`define IFD_DEST_BIT    8
`define IFD_BIT_OP_HI   13
`define IFD_BIT_OP_LO   11
`define IFD_BITNUM_HI   10
`define IFD_BITNUM_LO   8
`define IFD_LIT_OP_HI   13
`define IFD_LIT_OP_LO   8
`define IFD_CALL_BIT    13
`define IFD_FILE_W      8
`define IFD_PERI_W      5
`define IFD_LIT8_W      8
`define IFD_LIT13_W     13

// ----------------------------------------------------------------
// Group codes in the top two bits
// ----------------------------------------------------------------
`define IFD_GRP_BYTE    2'h0
`define IFD_GRP_LIT     2'h1
`define IFD_GRP_BIT     2'h2
`define IFD_GRP_CTRL    2'h3

// ----------------------------------------------------------------
// Defined codes inside each group
// ----------------------------------------------------------------
`define IFD_BYTE_LAST   5'h1D
`define IFD_BYTE_TBL_LO 5'h14
`define IFD_BYTE_TBL_HI 5'h17
`define IFD_BYTE_SKP_LO 5'h18
`define IFD_BYTE_SKP_HI 5'h19
`define IFD_BYTE_ALT_LO 5'h1A
`define IFD_BYTE_ALT_HI 5'h1B
`define IFD_BYTE_PER_LO 5'h1C
`define IFD_BYTE_PER_HI 5'h1D
`define IFD_BIT_SKP_LO  3'h6
`define IFD_LIT_LAST    6'h11
`define IFD_LIT_RET_LO  6'h10
`define IFD_NOP_WORD    16'h0000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define IFD_Q_PER_CYCLE 4
`define IFD_Q_LAST      2'h3
`define IFD_OPCODES     58

`endif

// ===== core/ifd_decoder.sv
// Instruction word decoder and four-phase cycle sequencer
`timescale 1ns/1ps
`include "ifd_cfg.svh"

// Functional notes
// - Take each instruction as one 16-bit word: opcode plus operands.
// - Exactly 58 distinct instructions are recognised.
// - Sort each word into byte, bit, or literal/control class.
// - Byte ops: d=0 result to working_accumulator, d=1 to file register.
// - Bit ops: bit-number field picks the bit, file field the register.
// - Literal/control ops carry an 8-bit or 13-bit constant.
// - One instruction cycle except taken tests, PC changes, table ops.
// - Table read/write take two cycles; second cycle is a no-operation.
// - Taken tests and PC changes take two instruction cycles.
// - Each instruction cycle spans four oscillator periods.
// - File register field is eight bits, 00h to FFh.
// - Peripheral register field is five bits, 00h to 1Fh.
// - Alternate destination: s=0 file and accumulator, s=1 file only.
// - Table pointer bit 1 increments table_pointer after execution.
module ifd_decoder #(
  parameter int WORD_W = `IFD_WORD_W
) (
  input  wire logic                       clk_sys,
  input  wire logic                       reset,
  input  wire logic [WORD_W-1:0]          instr_word,
  input  wire logic                       cond_true,
  output logic [1:0]                      q_phase,
  output logic                            cycle_start,
  output logic                            fetch_strobe,
  output ifd_pkg::ifd_class_t             instr_class,
  output logic [5:0]                      op_code,
  output logic                            op_valid,
  output logic                            op_reserved,
  output logic                            dummy_cycle,
  output logic [`IFD_FILE_W-1:0]          file_addr,
  output logic [`IFD_PERI_W-1:0]          periph_addr,
  output logic                            periph_op,
  output logic [2:0]                      bit_sel,
  output logic [`IFD_LIT8_W-1:0]          lit8,
  output logic [`IFD_LIT13_W-1:0]         lit13,
  output logic                            lit13_op,
  output logic                            wr_accum,
  output logic                            wr_file,
  output logic                            table_read,
  output logic                            table_write,
  output logic                            table_high,
  output logic                            table_ptr_inc,
  output logic                            pc_change,
  output logic                            skip_op
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic ifd_is_defined(input logic [WORD_W-1:0] w);
    logic [1:0] g;
    g = w[`IFD_GRP_HI:`IFD_GRP_LO];
    unique case (g)
      `IFD_GRP_BYTE:
        ifd_is_defined =
          (w[`IFD_BYTE_OP_HI:`IFD_BYTE_OP_LO] <= `IFD_BYTE_LAST);
      `IFD_GRP_LIT:
        ifd_is_defined =
          (w[`IFD_LIT_OP_HI:`IFD_LIT_OP_LO] <= `IFD_LIT_LAST);
      `IFD_GRP_BIT: ifd_is_defined = 1'b1;
      `IFD_GRP_CTRL: ifd_is_defined = 1'b1;
    endcase
  endfunction : ifd_is_defined

  function automatic logic ifd_in(input logic [4:0] v, input logic [4:0] lo,
                                  input logic [4:0] hi);
    ifd_in = (v >= lo) && (v <= hi);
  endfunction : ifd_in

  // ----------------------------------------------------------------
  // Phase counter
  // ----------------------------------------------------------------
  logic [1:0] q_cnt;
  logic [1:0] next_q_cnt;
  logic       boundary;

  always_comb begin
    next_q_cnt = q_cnt + 2'h1;
  end

  assign boundary = (q_cnt == `IFD_Q_LAST);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      q_cnt <= 2'h0;
    end else begin
      q_cnt <= next_q_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Fetch and sequence state
  // ----------------------------------------------------------------
  ifd_pkg::ifd_seq_t       seq;
  ifd_pkg::ifd_seq_t       next_seq;
  logic [WORD_W-1:0]       fetch_word;
  logic [WORD_W-1:0]       next_fetch_word;
  logic                    ex_two_cycle;
  logic                    ex_skip;
  logic                    next_ex_two_cycle;
  logic                    next_ex_skip;
  logic                    extend;

  // Executing word needs a second, empty cycle
  assign extend = ex_two_cycle || (ex_skip && cond_true);

  always_comb begin
    next_seq        = seq;
    next_fetch_word = fetch_word;
    if (boundary) begin
      next_fetch_word = instr_word;
      // Empty pipeline only after reset; extensions flush in place
      next_seq        = ifd_pkg::IFD_SEQ_EXEC;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      seq        <= ifd_pkg::IFD_SEQ_DUMMY;
      fetch_word <= `IFD_NOP_WORD;
    end else begin
      seq        <= next_seq;
      fetch_word <= next_fetch_word;
    end
  end

  // ----------------------------------------------------------------
  // Decode of the word entering execution
  // ----------------------------------------------------------------
  logic [WORD_W-1:0]      ex_word;
  logic [1:0]             grp;
  logic [4:0]             bop;
  logic [2:0]             kop;
  logic [5:0]             lop;
  logic                   flush;
  logic                   defined;

  ifd_pkg::ifd_class_t    d_class;
  logic [5:0]             d_op;
  logic                   d_wr_accum;
  logic                   d_wr_file;
  logic                   d_tbl_rd;
  logic                   d_tbl_wr;
  logic                   d_tbl_hi;
  logic                   d_tbl_inc;
  logic                   d_pc_chg;
  logic                   d_skip;
  logic                   d_periph;
  logic                   d_lit13;

  // Prefetched word is dropped when the current one extends
  assign flush   = (seq == ifd_pkg::IFD_SEQ_EXEC) && extend;
  assign ex_word = flush ? `IFD_NOP_WORD : fetch_word;
  assign grp     = ex_word[`IFD_GRP_HI:`IFD_GRP_LO];
  assign bop     = ex_word[`IFD_BYTE_OP_HI:`IFD_BYTE_OP_LO];
  assign kop     = ex_word[`IFD_BIT_OP_HI:`IFD_BIT_OP_LO];
  assign lop     = ex_word[`IFD_LIT_OP_HI:`IFD_LIT_OP_LO];
  assign defined = ifd_is_defined(ex_word);

  always_comb begin
    d_class    = ifd_pkg::IFD_CLS_BYTE;
    d_op       = 6'h00;
    d_wr_accum = 1'b0;
    d_wr_file  = 1'b0;
    d_tbl_rd   = 1'b0;
    d_tbl_wr   = 1'b0;
    d_tbl_hi   = 1'b0;
    d_tbl_inc  = 1'b0;
    d_pc_chg   = 1'b0;
    d_skip     = 1'b0;
    d_periph   = 1'b0;
    d_lit13    = 1'b0;
    if (defined) begin
      unique case (grp)
        `IFD_GRP_BYTE: begin
          d_class = ifd_pkg::IFD_CLS_BYTE;
          d_op    = {1'b0, bop};
          if (ifd_in(bop, `IFD_BYTE_TBL_LO, `IFD_BYTE_TBL_HI)) begin
            d_tbl_rd  = ~bop[1];
            d_tbl_wr  = bop[1];
            d_tbl_hi  = bop[0];
            d_tbl_inc = ex_word[`IFD_DEST_BIT];
            d_wr_file = ~bop[1];
          end else if (ifd_in(bop, `IFD_BYTE_ALT_LO,
                              `IFD_BYTE_ALT_HI)) begin
            d_wr_file  = 1'b1;
            d_wr_accum = ~ex_word[`IFD_DEST_BIT];
          end else if (ifd_in(bop, `IFD_BYTE_PER_LO,
                              `IFD_BYTE_PER_HI)) begin
            d_periph  = 1'b1;
            d_wr_file = 1'b1;
          end else begin
            d_wr_accum = ~ex_word[`IFD_DEST_BIT];
            d_wr_file  = ex_word[`IFD_DEST_BIT];
            d_skip     = ifd_in(bop, `IFD_BYTE_SKP_LO, `IFD_BYTE_SKP_HI);
          end
        end
        `IFD_GRP_BIT: begin
          d_class   = ifd_pkg::IFD_CLS_BIT;
          d_op      = {3'h0, kop};
          d_skip    = (kop >= `IFD_BIT_SKP_LO);
          d_wr_file = (kop < `IFD_BIT_SKP_LO);
        end
        `IFD_GRP_LIT: begin
          d_class    = ifd_pkg::IFD_CLS_LIT;
          d_op       = lop;
          d_pc_chg   = (lop >= `IFD_LIT_RET_LO);
          d_wr_accum = (lop != `IFD_LIT_RET_LO);
        end
        `IFD_GRP_CTRL: begin
          d_class  = ifd_pkg::IFD_CLS_LIT;
          d_op     = {5'h1F, ex_word[`IFD_CALL_BIT]};
          d_pc_chg = 1'b1;
          d_lit13  = 1'b1;
        end
      endcase
    end
  end

  always_comb begin
    next_ex_two_cycle = ex_two_cycle;
    next_ex_skip      = ex_skip;
    if (boundary) begin
      next_ex_two_cycle = (seq == ifd_pkg::IFD_SEQ_EXEC) && !extend &&
                          (d_pc_chg || d_tbl_rd || d_tbl_wr);
      next_ex_skip      = (seq == ifd_pkg::IFD_SEQ_EXEC) && !extend &&
                          d_skip;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ex_two_cycle <= 1'b0;
      ex_skip      <= 1'b0;
    end else begin
      ex_two_cycle <= next_ex_two_cycle;
      ex_skip      <= next_ex_skip;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  logic  ld;
  logic  live;

  // New word enters execution only outside a dummy cycle
  assign ld   = boundary;
  assign live = (seq == ifd_pkg::IFD_SEQ_EXEC) && !extend;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      q_phase       <= 2'h0;
      cycle_start   <= 1'b0;
      fetch_strobe  <= 1'b0;
      instr_class   <= ifd_pkg::IFD_CLS_BYTE;
      op_code       <= 6'h00;
      op_valid      <= 1'b0;
      op_reserved   <= 1'b0;
      dummy_cycle   <= 1'b1;
      file_addr     <= 8'h00;
      periph_addr   <= 5'h00;
      periph_op     <= 1'b0;
      bit_sel       <= 3'h0;
      lit8          <= 8'h00;
      lit13         <= 13'h0000;
      lit13_op      <= 1'b0;
      wr_accum      <= 1'b0;
      wr_file       <= 1'b0;
      table_read    <= 1'b0;
      table_write   <= 1'b0;
      table_high    <= 1'b0;
      table_ptr_inc <= 1'b0;
      pc_change     <= 1'b0;
      skip_op       <= 1'b0;
    end else begin
      q_phase      <= next_q_cnt;
      cycle_start  <= boundary;
      fetch_strobe <= (next_q_cnt == `IFD_Q_LAST);
      if (ld) begin
        instr_class   <= d_class;
        op_code       <= d_op;
        op_valid      <= live && defined;
        op_reserved   <= live && !defined;
        dummy_cycle   <= !live;
        file_addr     <= ex_word[`IFD_FILE_W-1:0];
        periph_addr   <= ex_word[`IFD_PERI_W-1:0];
        periph_op     <= live && d_periph;
        bit_sel       <= ex_word[`IFD_BITNUM_HI:`IFD_BITNUM_LO];
        lit8          <= ex_word[`IFD_LIT8_W-1:0];
        lit13         <= ex_word[`IFD_LIT13_W-1:0];
        lit13_op      <= live && d_lit13;
        wr_accum      <= live && d_wr_accum;
        wr_file       <= live && d_wr_file;
        table_read    <= live && d_tbl_rd;
        table_write   <= live && d_tbl_wr;
        table_high    <= live && d_tbl_hi;
        table_ptr_inc <= live && d_tbl_inc;
        pc_change     <= live && d_pc_chg;
        skip_op       <= live && d_skip;
      end
    end
  end

endmodule : ifd_decoder

// ===== core/ifd_pkg.sv
// Types shared by the instruction decoder
package ifd_pkg;

  typedef enum logic [1:0] {
    IFD_CLS_BYTE,
    IFD_CLS_BIT,
    IFD_CLS_LIT
  } ifd_class_t;

  typedef enum logic {
    IFD_SEQ_EXEC,
    IFD_SEQ_DUMMY
  } ifd_seq_t;

endpackage : ifd_pkg

// ===== verif/ifd_decoder_properties.sv
// Timing and gating properties of the instruction decoder
`timescale 1ns/1ps
module ifd_decoder_properties (
  input wire logic       clk_sys,
  input wire logic       reset,
  input wire logic       cond_true,
  input wire logic [1:0] q_phase,
  input wire logic       cycle_start,
  input wire logic       fetch_strobe,
  input wire logic       op_valid,
  input wire logic       op_reserved,
  input wire logic       dummy_cycle,
  input wire logic       wr_accum,
  input wire logic       wr_file,
  input wire logic       table_read,
  input wire logic       table_write,
  input wire logic       pc_change,
  input wire logic       skip_op
);
  logic strobes;
  assign strobes = wr_accum | wr_file | table_read | table_write
                   | pc_change | skip_op;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_next_cycle;
    !cycle_start [*3] ##1 cycle_start;
  endsequence
  sequence s_next_dummy;
    ##4 (cycle_start && dummy_cycle);
  endsequence

  a_phase_count: assert property (
    !reset |=> q_phase == $past(q_phase) + 2'h1)
    else $error("phase skipped");
  a_cycle_len: assert property (
    cycle_start |=> s_next_cycle)
    else $error("cycle not four clocks");
  a_fetch_phase: assert property (
    fetch_strobe == (q_phase == 2'h3))
    else $error("fetch outside last phase");
  a_hold_cycle: assert property (
    !cycle_start |-> $stable(strobes) && $stable(dummy_cycle)
    && $stable(op_valid))
    else $error("controls moved in mid cycle");
  a_pc_dummy: assert property (
    cycle_start && pc_change |-> s_next_dummy)
    else $error("no dummy after branch");
  a_table_dummy: assert property (
    (table_read || table_write) && cycle_start |-> s_next_dummy)
    else $error("no dummy after table");
  a_skip_taken: assert property (
    fetch_strobe && skip_op && cond_true |=> dummy_cycle)
    else $error("taken skip ran next word");
  a_skip_fall: assert property (
    fetch_strobe && skip_op && !cond_true |=> !dummy_cycle)
    else $error("untaken skip lost a cycle");
  a_one_cycle: assert property (
    cycle_start && op_valid && !pc_change && !table_read
    && !table_write && !skip_op |-> ##4 !dummy_cycle)
    else $error("single cycle op stretched");
  a_dummy_quiet: assert property (
    dummy_cycle |-> !strobes)
    else $error("strobe in dummy cycle");
  a_reserved_quiet: assert property (
    op_reserved |-> !op_valid && !strobes)
    else $error("reserved code acted");
endmodule : ifd_decoder_properties

bind ifd_decoder ifd_decoder_properties u_props (
  .clk_sys(clk_sys), .reset(reset), .cond_true(cond_true),
  .q_phase(q_phase), .cycle_start(cycle_start),
  .fetch_strobe(fetch_strobe), .op_valid(op_valid),
  .op_reserved(op_reserved), .dummy_cycle(dummy_cycle),
  .wr_accum(wr_accum), .wr_file(wr_file), .table_read(table_read),
  .table_write(table_write), .pc_change(pc_change), .skip_op(skip_op)
);

// ===== verif/ifd_prog_mem.sv
// Program memory model feeding instruction words to the decoder
`timescale 1ns/1ps
module ifd_prog_mem (
  input  wire logic   clk_sys,
  input  wire logic   reset,
  input  wire logic   fetch_strobe,
  output logic [15:0] instr_word
);
  logic [15:0] rom [16];
  logic [3:0]  addr;

  initial instr_word = 16'h0000;

  // Address steps once per taken word
  always @(posedge clk_sys) begin
    if (reset)
      addr <= 4'h0;
    else if (fetch_strobe)
      addr <= addr + 4'h1;
  end

  // Word valid only while fetched, inverted otherwise
  always @(negedge clk_sys) begin
    instr_word <= fetch_strobe ? rom[addr] : ~rom[addr];
  end
endmodule : ifd_prog_mem

// ===== verif/instruction_format_decoder_bench.sv
// Self-checking bench: decoder fed by a program memory model
`timescale 1ns/1ps
module instruction_format_decoder_bench;
  logic        clk_sys, reset, cond_true;
  logic [15:0] instr_word;
  logic [12:0] lit13;
  logic [7:0]  file_addr, lit8;
  logic [5:0]  op_code;
  logic [4:0]  periph_addr;
  logic [2:0]  bit_sel;
  logic [1:0]  q_phase;
  logic        cycle_start, fetch_strobe, op_valid, op_reserved;
  logic        dummy_cycle, periph_op, lit13_op, wr_accum, wr_file;
  logic        table_read, table_write, table_high, table_ptr_inc;
  logic        pc_change, skip_op;
  ifd_pkg::ifd_class_t instr_class;
  int          miscompares = 0, n_checks = 0, cycles = 0;
  localparam ifd_pkg::ifd_class_t cls_byte = ifd_pkg::IFD_CLS_BYTE;
  localparam ifd_pkg::ifd_class_t cls_lit = ifd_pkg::IFD_CLS_LIT;

  ifd_decoder dut (
    .clk_sys(clk_sys), .reset(reset), .instr_word(instr_word),
    .cond_true(cond_true), .q_phase(q_phase), .cycle_start(cycle_start),
    .fetch_strobe(fetch_strobe), .instr_class(instr_class),
    .op_code(op_code), .op_valid(op_valid), .op_reserved(op_reserved),
    .dummy_cycle(dummy_cycle), .file_addr(file_addr),
    .periph_addr(periph_addr), .periph_op(periph_op), .bit_sel(bit_sel),
    .lit8(lit8), .lit13(lit13), .lit13_op(lit13_op), .wr_accum(wr_accum),
    .wr_file(wr_file), .table_read(table_read),
    .table_write(table_write), .table_high(table_high),
    .table_ptr_inc(table_ptr_inc), .pc_change(pc_change),
    .skip_op(skip_op)
  );

  ifd_prog_mem mem (
    .clk_sys(clk_sys), .reset(reset), .fetch_strobe(fetch_strobe),
    .instr_word(instr_word)
  );

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      conclude;
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [23:0] g, input logic [23:0] e,
                     input string m);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic start(input logic [63:0] p, input logic c);
    int i;
    for (i = 0; i < 16; i++)
      mem.rom[i] = (i < 4) ? p[63-16*i -: 16] : 16'h0000;
    cond_true = c;
    reset = 1'b1;
    repeat (6) @(negedge clk_sys);
    chk(24'({q_phase, dummy_cycle, wr_file}), 24'h2, "reset state");
    reset = 1'b0;
    for (i = 0; i < 32; i++) begin
      @(negedge clk_sys);
      if (cycle_start === 1'b1 && dummy_cycle === 1'b0)
        break;
    end
    chk(24'(cycle_start), 24'h1, "no executed cycle");
  endtask : start

  task automatic nxt;
    repeat (4) @(negedge clk_sys);
    chk(24'({cycle_start, q_phase}), 24'h4, "cycle length");
  endtask : nxt

  task automatic ex(input ifd_pkg::ifd_class_t c, input logic [5:0] o);
    chk(24'({dummy_cycle, op_valid, op_reserved, instr_class, op_code}),
        24'({3'b010, c, o}), "decoded op");
  endtask : ex

  task automatic fl(input logic [9:0] f);
    chk(24'({wr_accum, wr_file, table_read, table_write, table_high,
        table_ptr_inc, pc_change, skip_op, periph_op, lit13_op}),
        24'(f), "controls");
  endtask : fl

  task automatic dm;
    chk(24'({dummy_cycle, pc_change, wr_file, wr_accum}), 24'h8, "dummy");
  endtask : dm

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_byte;
    start({16'h02A5, 16'h035A, 16'h3433, 16'h3533}, 1'b1);
    ex(cls_byte, 6'h01);
    fl(10'h200);
    chk(24'(file_addr), 24'hA5, "file field");
    nxt;
    fl(10'h100);
    nxt;
    ex(cls_byte, 6'h1A);
    fl(10'h300);
    nxt;
    fl(10'h100);
    $display("byte test done");
  endtask : t_byte

  task automatic t_misc;
    start({16'h97FF, 16'h453C, 16'h381F, 16'h3C00}, 1'b0);
    ex(ifd_pkg::IFD_CLS_BIT, 6'h02);
    chk(24'({bit_sel, file_addr}), 24'h7FF, "bit fields");
    nxt;
    ex(cls_lit, 6'h05);
    chk(24'(lit8), 24'h3C, "literal");
    nxt;
    chk(24'({periph_op, periph_addr}), 24'h3F, "periph");
    nxt;
    chk(24'({op_reserved, op_valid, wr_file}), 24'h4, "reserved");
    $display("field test done");
  endtask : t_misc

  task automatic t_goto;
    start({16'hDABC, 16'h02A5, 16'h035A, 16'hE123}, 1'b0);
    ex(cls_lit, 6'h3E);
    chk(24'(lit13), 24'h1ABC, "long literal");
    fl(10'h009);
    nxt;
    dm;
    nxt;
    fl(10'h100);
    nxt;
    ex(cls_lit, 6'h3F);
    chk(24'({pc_change, lit13}), 24'h2123, "call");
    $display("branch test done");
  endtask : t_goto

  task automatic t_skip_taken;
    start({16'h3012, 16'h02A5, 16'h035A, 16'h0000}, 1'b1);
    ex(cls_byte, 6'h18);
    chk(24'(skip_op), 24'h1, "skip flag");
    nxt;
    dm;
    nxt;
    fl(10'h100);
    $display("taken skip test done");
  endtask : t_skip_taken

  task automatic t_skip_not;
    start({16'h3012, 16'h02A5, 16'h035A, 16'h0000}, 1'b0);
    nxt;
    ex(cls_byte, 6'h01);
    fl(10'h200);
    $display("untaken skip test done");
  endtask : t_skip_not

  task automatic t_table;
    start({16'h2910, 16'h02A5, 16'h2E44, 16'h035A}, 1'b0);
    ex(cls_byte, 6'h14);
    fl(10'h190);
    nxt;
    dm;
    nxt;
    ex(cls_byte, 6'h17);
    fl(10'h060);
    nxt;
    dm;
    nxt;
    ex(cls_byte, 6'h00);
    $display("table test done");
  endtask : t_table

  task automatic conclude;
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  initial begin
    reset = 1'b1;
    cond_true = 1'b0;
    @(negedge clk_sys);
    t_byte;
    t_misc;
    t_goto;
    t_skip_taken;
    t_skip_not;
    t_table;
    conclude;
  end
endmodule : instruction_format_decoder_bench
